// ### include/lan_pkg.sv
// Shared constants and types for both ends of the start-up link
// Functional notes
// - all eight lamps flash ten seconds first
// - progress lamp on, code counts upward
// - each code shown at least 100 ms
// - no code skipped between first and last
// - pass shows zero code five seconds
// - after pass lamps show controller activity
// - failing code held 20 s, lamp blinks; code holds it past 20 s until the host has sent a command
// - seven separate lamps show cable activity
// - host starts download, device DMA moves
// - checksum over local RAM versus host's
// - image may arrive in several downloads
// - halt then dump RAM and status
// - start loaded firmware, then accept configuration
// - readable 48-bit address held in ROM
// - candidate sent as XID destination
// - wait for echo before adopting address
// - echo reports failure, address not adopted
// - commands and responses through memory queues
// - host programs queue size and entry length
// - host announces new commands by poll
// - new response raises system interrupt
// - buffer moves run without host help
// - self-test end or failure raises interrupt
package lan_pkg;
	localparam int CLK_KHZ = 40000;
	localparam int FLASH_MS = 10000;
	localparam int CODE_MS = 100;
	localparam int PASS_MS = 5000;
	localparam int FAIL_MS = 20000;
	localparam int BLINK_MS = 500;
	localparam int DAC_MS = 2;
	localparam logic [6:0] CODE_FIRST = 7'h01;
	localparam logic [6:0] CODE_LAST = 7'h2e;
	localparam logic [6:0] CODE_PASS = 7'h00;
	localparam int HEAD_OFS = 0;
	localparam int TAIL_OFS = 1;
	localparam int ENT_OFS = 2;
	// Arbitrary value for the burned-in station address
	localparam logic [47:0] ROM_STATION = 48'h0000_1234_5678;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_DOWNLOAD = 4'h1, OP_START = 4'h2, OP_HALT = 4'h3,
		OP_READ_ROM = 4'h4, OP_SET_ADDR = 4'h5, OP_CMDQ_CFG = 4'h6, OP_RSPQ_CFG = 4'h7,
		OP_POLL = 4'h8, OP_CLR_IRQ = 4'h9
	} op_e;
	typedef enum logic [2:0] {
		STAT_OK = 3'h0, STAT_BAD_SUM = 3'h1, STAT_DUP_ADDR = 3'h2, STAT_REFUSED = 3'h3, STAT_BUSY = 3'h4
	} stat_e;
	typedef enum logic [2:0] {
		P_FLASH = 3'h0, P_RUN = 3'h1, P_PASS = 3'h3, P_LIVE = 3'h2, P_FAIL = 3'h6
	} lamp_e;
	typedef enum logic [3:0] {
		C_IDLE = 4'h0, C_DL = 4'h1, C_SUM = 4'h3, C_DUMP = 4'h2, C_DSTAT = 4'h6, C_DAC = 4'h7,
		C_PTAIL = 4'h5, C_PENT = 4'h4, C_PHEAD = 4'hc, C_RENT = 4'hd, C_RTAIL = 4'hf
	} cs_e;
	typedef enum logic [1:0] {H_IDLE = 2'h0, H_SUM = 2'h1, H_CMD = 2'h3} hs_e;
endpackage

// ### include/lan_link_if.sv
// Backplane link between host and network card
`timescale 1ns/1ps
interface lan_link_if #(parameter int AW = 16);
	logic cmd_valid;
	lan_pkg::op_e cmd_op;
	logic [AW-1:0] cmd_addr;
	logic [15:0] cmd_len;
	logic [47:0] cmd_data;
	logic cmd_done;
	lan_pkg::stat_e cmd_status;
	logic [47:0] cmd_rdata;
	logic mem_req;
	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic [31:0] mem_wdata;
	logic mem_ack;
	logic [31:0] mem_rdata;
	logic resp_irq;
	logic selftest_irq;
	modport dev (input cmd_valid, cmd_op, cmd_addr, cmd_len, cmd_data, mem_ack, mem_rdata,
		output cmd_done, cmd_status, cmd_rdata, mem_req, mem_we, mem_addr, mem_wdata, resp_irq, selftest_irq);
	modport host (output cmd_valid, cmd_op, cmd_addr, cmd_len, cmd_data, mem_ack, mem_rdata,
		input cmd_done, cmd_status, cmd_rdata, mem_req, mem_we, mem_addr, mem_wdata, resp_irq, selftest_irq);
endinterface

// ### hw/interval_timer.sv
// Loadable down-counter with an expiry flag
`timescale 1ns/1ps
module interval_timer #(
	parameter int W = 30
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic expired
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic exp;
	} tmr_s;
	tmr_s s_reg, s_next;
	assign expired = s_reg.exp;
	always_comb
	begin
		s_next = s_reg;
		if (load)
		begin
			s_next.cnt = value - W'(1);
			s_next.exp = 1'b0;
		end
		else if (s_reg.cnt != '0)
			s_next.cnt = s_reg.cnt - W'(1);
		else
			s_next.exp = 1'b1;
	end
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
endmodule // interval_timer

// ### hw/lan_dev_end.sv
// Card end: self-test lamps, download, address check, queues
`timescale 1ns/1ps
module lan_dev_end #(
	parameter int AW = 16,
	parameter int RAM_WORDS = 256,
	parameter int TW = 30,
	parameter int FLASH_CYC = lan_pkg::CLK_KHZ * lan_pkg::FLASH_MS,
	parameter int CODE_CYC = lan_pkg::CLK_KHZ * lan_pkg::CODE_MS,
	parameter int PASS_CYC = lan_pkg::CLK_KHZ * lan_pkg::PASS_MS,
	parameter int FAIL_CYC = lan_pkg::CLK_KHZ * lan_pkg::FAIL_MS,
	parameter int BLINK_CYC = lan_pkg::CLK_KHZ * lan_pkg::BLINK_MS,
	parameter int DAC_CYC = lan_pkg::CLK_KHZ * lan_pkg::DAC_MS,
	parameter logic [47:0] ROM_STATION = lan_pkg::ROM_STATION
) (
	lan_link_if.dev link,
	input wire logic core_clk,
	input wire logic rst_n,
	output logic progress_lamp,
	output logic [6:0] code_lamps,
	output logic [6:0] aui_lamps,
	input wire logic [6:0] aui_act,
	input wire logic [6:0] ctl_act,
	output logic test_start,
	output logic [6:0] test_code,
	input wire logic test_done,
	input wire logic test_pass,
	output logic xid_send,
	output logic [47:0] xid_dest,
	input wire logic xid_echo,
	output logic command_queue_valid,
	output logic [31:0] command_queue_word,
	input wire logic rsp_push,
	input wire logic [31:0] rsp_word,
	output logic rsp_ready,
	output logic fw_running
);
	localparam int LW = $clog2(RAM_WORDS);
	typedef struct packed {
		lan_pkg::lamp_e phase;
		logic armed, blink, touched, go, tdone, tpass, prog;
		logic [6:0] code, aui;
		lan_pkg::cs_e cs;
		logic done;
		lan_pkg::stat_e stat;
		logic [47:0] rdata, station, cand;
		logic xid, fw, dl_ok;
		logic mreq, mwe;
		logic [AW-1:0] maddr, sb, cmdq_b, rspq_b;
		logic [31:0] mwdata, sum, want, cmdq_w;
		logic [15:0] idx, len, lb, cmdq_n, cmdq_e, cmdq_h, rspq_n, rspq_e, rspq_t;
		logic cmdq_ok, rspq_ok, cmdq_v, rrdy, rirq, sirq;
	} dev_s;
	dev_s s, n;
	logic [31:0] ram [RAM_WORDS];
	logic ram_we;
	logic [LW-1:0] ram_a;
	logic [31:0] ram_rd;
	logic tl_load, tl_exp, tb_load, tb_exp, td_load, td_exp;
	logic [TW-1:0] tl_val;
	logic live;

	// Entry address; pointers sit ahead of entries
	function automatic logic [AW-1:0] qaddr(input logic [AW-1:0] b, input logic [15:0] e, input logic [15:0] i);
		logic [31:0] p;
		p = e * i;
		return b + AW'(lan_pkg::ENT_OFS) + p[AW-1:0];
	endfunction
	function automatic logic [15:0] wrap(input logic [15:0] p, input logic [15:0] size);
		return (p + 16'h0001 == size) ? 16'h0000 : p + 16'h0001;
	endfunction

	assign ram_rd = ram[ram_a];
	always_ff @(posedge core_clk)
	begin
		if (ram_we)
			ram[ram_a] <= link.mem_rdata;
	end

	interval_timer #(.W(TW)) lamp_tmr (.core_clk(core_clk), .rst_n(rst_n), .load(tl_load), .value(tl_val),
		.expired(tl_exp));
	interval_timer #(.W(TW)) blink_tmr (.core_clk(core_clk), .rst_n(rst_n), .load(tb_load),
		.value(TW'(BLINK_CYC)), .expired(tb_exp));
	interval_timer #(.W(TW)) dac_tmr (.core_clk(core_clk), .rst_n(rst_n), .load(td_load),
		.value(TW'(DAC_CYC)), .expired(td_exp));

	assign live = (s.phase == lan_pkg::P_LIVE) || (s.phase == lan_pkg::P_FAIL);

	always_comb
	begin
		n = s;
		n.done = 1'b0;
		n.xid = 1'b0;
		n.go = 1'b0;
		n.cmdq_v = 1'b0;
		ram_we = 1'b0;
		ram_a = LW'(s.lb + s.idx);
		tl_load = 1'b0;
		tl_val = TW'(CODE_CYC);
		td_load = 1'b0;
		// Free-running so flash and fail blink share it
		tb_load = !s.armed || tb_exp;
		if (tb_exp)
			n.blink = ~s.blink;
		n.aui = aui_act;
		case (s.cs)
			lan_pkg::C_IDLE:
				if (!s.done)
				begin
					if (rsp_push && s.rrdy)
					begin
						n.mwdata = rsp_word;
						n.cs = lan_pkg::C_RENT;
					end
					else if (link.cmd_valid)
					begin
						n.touched = 1'b1;
						n.done = 1'b1;
						n.stat = lan_pkg::STAT_OK;
						if (!live)
							n.stat = lan_pkg::STAT_BUSY;
						else
							case (link.cmd_op)
								lan_pkg::OP_DOWNLOAD:
									if (s.fw)
										n.stat = lan_pkg::STAT_REFUSED;
									else
									begin
										n.done = 1'b0;
										n.cs = lan_pkg::C_DL;
										n.sb = link.cmd_addr;
										n.len = link.cmd_len;
										n.lb = link.cmd_data[47:32];
										n.want = link.cmd_data[31:0];
										n.idx = '0;
										n.dl_ok = 1'b0;
									end
								lan_pkg::OP_START:
									if (s.dl_ok)
										n.fw = 1'b1;
									else
										n.stat = lan_pkg::STAT_REFUSED;
								lan_pkg::OP_HALT:
								begin
									n.fw = 1'b0;
									n.done = 1'b0;
									n.cs = lan_pkg::C_DUMP;
									n.sb = link.cmd_addr;
									n.idx = '0;
									n.lb = '0;
									n.len = 16'(RAM_WORDS);
								end
								lan_pkg::OP_READ_ROM:
									n.rdata = ROM_STATION;
								lan_pkg::OP_SET_ADDR:
									if (!s.fw)
										n.stat = lan_pkg::STAT_REFUSED;
									else
									begin
										n.done = 1'b0;
										n.cand = link.cmd_data;
										n.xid = 1'b1;
										td_load = 1'b1;
										n.cs = lan_pkg::C_DAC;
									end
								lan_pkg::OP_CMDQ_CFG:
									if (!s.fw)
										n.stat = lan_pkg::STAT_REFUSED;
									else
									begin
										n.cmdq_b = link.cmd_addr;
										n.cmdq_n = link.cmd_len;
										n.cmdq_e = link.cmd_data[15:0];
										n.cmdq_h = '0;
										n.cmdq_ok = (link.cmd_len != '0) && (link.cmd_data[15:0] != '0);
									end
								lan_pkg::OP_RSPQ_CFG:
									if (!s.fw)
										n.stat = lan_pkg::STAT_REFUSED;
									else
									begin
										n.rspq_b = link.cmd_addr;
										n.rspq_n = link.cmd_len;
										n.rspq_e = link.cmd_data[15:0];
										n.rspq_t = '0;
										n.rspq_ok = (link.cmd_len != '0) && (link.cmd_data[15:0] != '0);
									end
								lan_pkg::OP_POLL:
									if (!s.cmdq_ok)
										n.stat = lan_pkg::STAT_REFUSED;
									else
									begin
										n.done = 1'b0;
										n.cs = lan_pkg::C_PTAIL;
									end
								lan_pkg::OP_CLR_IRQ:
								begin
									n.rirq = 1'b0;
									n.sirq = 1'b0;
								end
								default:
									n.stat = lan_pkg::STAT_REFUSED;
							endcase
					end
				end
			lan_pkg::C_DL:
				if (!s.mreq)
				begin
					if (s.idx == s.len)
					begin
						n.cs = lan_pkg::C_SUM;
						n.idx = '0;
						n.sum = '0;
					end
					else
					begin
						n.mreq = 1'b1;
						n.mwe = 1'b0;
						n.maddr = s.sb + AW'(s.idx);
					end
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					ram_we = 1'b1;
					n.idx = s.idx + 16'h0001;
				end
			lan_pkg::C_SUM:
				if (s.idx == s.len)
				begin
					n.done = 1'b1;
					n.dl_ok = (s.sum == s.want);
					n.stat = (s.sum == s.want) ? lan_pkg::STAT_OK : lan_pkg::STAT_BAD_SUM;
					n.cs = lan_pkg::C_IDLE;
				end
				else
				begin
					n.sum = s.sum + ram_rd;
					n.idx = s.idx + 16'h0001;
				end
			lan_pkg::C_DUMP:
				if (!s.mreq)
				begin
					if (s.idx == s.len)
						n.cs = lan_pkg::C_DSTAT;
					else
					begin
						n.mreq = 1'b1;
						n.mwe = 1'b1;
						n.maddr = s.sb + AW'(s.idx);
						n.mwdata = ram_rd;
					end
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					n.idx = s.idx + 16'h0001;
				end
			lan_pkg::C_DSTAT:
				if (!s.mreq)
				begin
					n.mreq = 1'b1;
					n.mwe = 1'b1;
					n.maddr = s.sb + AW'(s.len);
					n.mwdata = {s.cmdq_h, s.rspq_t};
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					n.done = 1'b1;
					n.stat = lan_pkg::STAT_OK;
					n.cs = lan_pkg::C_IDLE;
				end
			lan_pkg::C_DAC:
				if (xid_echo)
				begin
					n.done = 1'b1;
					n.stat = lan_pkg::STAT_DUP_ADDR;
					n.cs = lan_pkg::C_IDLE;
				end
				else if (td_exp)
				begin
					n.station = s.cand;
					n.done = 1'b1;
					n.stat = lan_pkg::STAT_OK;
					n.cs = lan_pkg::C_IDLE;
				end
			lan_pkg::C_PTAIL:
				if (!s.mreq)
				begin
					n.mreq = 1'b1;
					n.mwe = 1'b0;
					n.maddr = s.cmdq_b + AW'(lan_pkg::TAIL_OFS);
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					if (link.mem_rdata[15:0] == s.cmdq_h)
					begin
						n.done = 1'b1;
						n.stat = lan_pkg::STAT_OK;
						n.cs = lan_pkg::C_IDLE;
					end
					else
						n.cs = lan_pkg::C_PENT;
				end
			lan_pkg::C_PENT:
				if (!s.mreq)
				begin
					n.mreq = 1'b1;
					n.mwe = 1'b0;
					n.maddr = qaddr(s.cmdq_b, s.cmdq_e, s.cmdq_h);
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					n.cmdq_v = 1'b1;
					n.cmdq_w = link.mem_rdata;
					n.cmdq_h = wrap(s.cmdq_h, s.cmdq_n);
					n.cs = lan_pkg::C_PHEAD;
				end
			lan_pkg::C_PHEAD:
				if (!s.mreq)
				begin
					n.mreq = 1'b1;
					n.mwe = 1'b1;
					n.maddr = s.cmdq_b + AW'(lan_pkg::HEAD_OFS);
					n.mwdata = 32'(s.cmdq_h);
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					n.cs = lan_pkg::C_PTAIL;
				end
			lan_pkg::C_RENT:
				if (!s.mreq)
				begin
					n.mreq = 1'b1;
					n.mwe = 1'b1;
					n.maddr = qaddr(s.rspq_b, s.rspq_e, s.rspq_t);
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					n.rspq_t = wrap(s.rspq_t, s.rspq_n);
					n.cs = lan_pkg::C_RTAIL;
				end
			lan_pkg::C_RTAIL:
				if (!s.mreq)
				begin
					n.mreq = 1'b1;
					n.mwe = 1'b1;
					n.maddr = s.rspq_b + AW'(lan_pkg::TAIL_OFS);
					n.mwdata = 32'(s.rspq_t);
				end
				else if (link.mem_ack)
				begin
					n.mreq = 1'b0;
					n.rirq = 1'b1;
					n.cs = lan_pkg::C_IDLE;
				end
			default:
				n.cs = lan_pkg::C_IDLE;
		endcase
		// After the decode so a lamp irq set beats a clear
		case (s.phase)
			lan_pkg::P_FLASH:
			begin
				n.prog = s.blink;
				n.code = {7{s.blink}};
				if (!s.armed)
				begin
					n.armed = 1'b1;
					tl_load = 1'b1;
					tl_val = TW'(FLASH_CYC);
				end
				else if (tl_exp)
				begin
					n.phase = lan_pkg::P_RUN;
					n.prog = 1'b1;
					n.code = lan_pkg::CODE_FIRST;
					n.go = 1'b1;
					n.tdone = 1'b0;
					tl_load = 1'b1;
				end
			end
			lan_pkg::P_RUN:
			begin
				if (test_done && !s.tdone)
				begin
					n.tdone = 1'b1;
					n.tpass = test_pass;
				end
				if (s.tdone && tl_exp)
				begin
					tl_load = 1'b1;
					if (!s.tpass)
					begin
						n.phase = lan_pkg::P_FAIL;
						tl_val = TW'(FAIL_CYC);
						n.sirq = 1'b1;
					end
					else if (s.code == lan_pkg::CODE_LAST)
					begin
						n.phase = lan_pkg::P_PASS;
						n.code = lan_pkg::CODE_PASS;
						tl_val = TW'(PASS_CYC);
						n.sirq = 1'b1;
					end
					else
					begin
						n.code = s.code + 7'h01;
						n.go = 1'b1;
						n.tdone = 1'b0;
					end
				end
			end
			lan_pkg::P_PASS:
				if (tl_exp)
				begin
					n.phase = lan_pkg::P_LIVE;
					n.prog = 1'b0;
				end
			lan_pkg::P_LIVE:
			begin
				n.prog = 1'b0;
				n.code = ctl_act;
			end
			lan_pkg::P_FAIL:
			begin
				n.prog = s.blink;
				if (tl_exp && s.touched)
					n.phase = lan_pkg::P_LIVE;
			end
			default:
				n.phase = lan_pkg::P_FLASH;
		endcase
		n.rrdy = (n.cs == lan_pkg::C_IDLE) && n.rspq_ok && n.fw && !n.done;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign progress_lamp = s.prog;
	assign code_lamps = s.code;
	assign aui_lamps = s.aui;
	assign test_start = s.go;
	assign test_code = s.code;
	assign xid_send = s.xid;
	assign xid_dest = s.cand;
	assign command_queue_valid = s.cmdq_v;
	assign command_queue_word = s.cmdq_w;
	assign rsp_ready = s.rrdy;
	assign fw_running = s.fw;
	assign link.cmd_done = s.done;
	assign link.cmd_status = s.stat;
	assign link.cmd_rdata = s.rdata;
	assign link.mem_req = s.mreq;
	assign link.mem_we = s.mwe;
	assign link.mem_addr = s.maddr;
	assign link.mem_wdata = s.mwdata;
	assign link.resp_irq = s.rirq;
	assign link.selftest_irq = s.sirq;
endmodule // lan_dev_end

// ### hw/lan_host_end.sv
// Host end: system memory, checksum for downloads, command issue
`timescale 1ns/1ps
module lan_host_end #(
	parameter int AW = 16,
	parameter int MEM_WORDS = 4096
) (
	lan_link_if.host link,
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire lan_pkg::op_e req_op,
	input wire logic [AW-1:0] req_addr,
	input wire logic [15:0] req_len,
	input wire logic [47:0] req_data,
	output logic req_ready,
	output logic resp_done,
	output lan_pkg::stat_e resp_status,
	output logic [47:0] resp_data,
	output logic resp_irq_out,
	output logic selftest_irq_out,
	input wire logic load_we,
	input wire logic [AW-1:0] load_addr,
	input wire logic [31:0] load_data
);
	localparam int MW = $clog2(MEM_WORDS);
	typedef struct packed {
		lan_pkg::hs_e hs;
		logic cvalid;
		lan_pkg::op_e op;
		logic [AW-1:0] addr;
		logic [15:0] len, idx;
		logic [47:0] data, rdata;
		logic [31:0] sum, mrd;
		logic ack, rdy, done, rirq, sirq;
		lan_pkg::stat_e stat;
	} host_s;
	host_s s, n;
	// Higher addresses alias; keep images inside MEM_WORDS
	logic [31:0] mem [MEM_WORDS];
	logic [31:0] sum_rd;

	assign sum_rd = mem[MW'(s.addr + AW'(s.idx))];
	always_ff @(posedge core_clk)
	begin
		if (load_we)
			mem[MW'(load_addr)] <= load_data;
		else if (link.mem_req && link.mem_we && !s.ack)
			mem[MW'(link.mem_addr)] <= link.mem_wdata;
	end

	always_comb
	begin
		n = s;
		n.done = 1'b0;
		n.ack = link.mem_req && !s.ack;
		n.mrd = mem[MW'(link.mem_addr)];
		n.rirq = link.resp_irq;
		n.sirq = link.selftest_irq;
		case (s.hs)
			lan_pkg::H_IDLE:
				if (req_valid && s.rdy)
				begin
					n.op = req_op;
					n.addr = req_addr;
					n.len = req_len;
					n.data = req_data;
					n.idx = '0;
					n.sum = '0;
					if (req_op == lan_pkg::OP_DOWNLOAD)
						n.hs = lan_pkg::H_SUM;
					else
					begin
						n.cvalid = 1'b1;
						n.hs = lan_pkg::H_CMD;
					end
				end
			lan_pkg::H_SUM:
				if (s.idx == s.len)
				begin
					n.data[31:0] = s.sum;
					n.cvalid = 1'b1;
					n.hs = lan_pkg::H_CMD;
				end
				else
				begin
					n.sum = s.sum + sum_rd;
					n.idx = s.idx + 16'h0001;
				end
			lan_pkg::H_CMD:
				if (link.cmd_done)
				begin
					n.cvalid = 1'b0;
					n.done = 1'b1;
					n.stat = link.cmd_status;
					n.rdata = link.cmd_rdata;
					n.hs = lan_pkg::H_IDLE;
				end
			default:
				n.hs = lan_pkg::H_IDLE;
		endcase
		n.rdy = (n.hs == lan_pkg::H_IDLE) && !(s.hs == lan_pkg::H_IDLE && req_valid && s.rdy);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign link.cmd_valid = s.cvalid;
	assign link.cmd_op = s.op;
	assign link.cmd_addr = s.addr;
	assign link.cmd_len = s.len;
	assign link.cmd_data = s.data;
	assign link.mem_ack = s.ack;
	assign link.mem_rdata = s.mrd;
	assign req_ready = s.rdy;
	assign resp_done = s.done;
	assign resp_status = s.stat;
	assign resp_data = s.rdata;
	assign resp_irq_out = s.rirq;
	assign selftest_irq_out = s.sirq;
endmodule // lan_host_end

// ### test/lan_controller_startup_selftest_props.sv
// Checker on the host-to-card link signals
`timescale 1ns/1ps
module lan_controller_startup_selftest_props #(
	parameter logic [47:0] ROM_STATION = lan_pkg::ROM_STATION
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire lan_pkg::op_e cmd_op,
	input wire logic cmd_done,
	input wire lan_pkg::stat_e cmd_status,
	input wire logic [47:0] cmd_rdata,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic resp_irq,
	input wire logic selftest_irq
);
	logic st_seen_reg;
	// Sticky across irq clears
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st_seen_reg <= 1'b0;
		else if (selftest_irq)
			st_seen_reg <= 1'b1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped before ack");
	AST_MEM_GAP: assert property (mem_ack |=> !mem_req) else $error("no gap after ack");
	AST_DONE_PULSE: assert property (cmd_done |=> !cmd_done) else $error("done wider than one cycle");
	AST_DONE_CMD: assert property (cmd_done |-> cmd_valid) else $error("done without command");
	AST_BUSY: assert property (cmd_done && !st_seen_reg && !selftest_irq |-> cmd_status == lan_pkg::STAT_BUSY)
		else $error("command served during self-test");
	AST_RIRQ_CLR: assert property ($fell(resp_irq) |-> $past(cmd_valid) && $past(cmd_op) == lan_pkg::OP_CLR_IRQ)
		else $error("response irq dropped on its own");
	AST_SIRQ_CLR: assert property ($fell(selftest_irq) |-> $past(cmd_valid) && $past(cmd_op) == lan_pkg::OP_CLR_IRQ)
		else $error("self-test irq dropped on its own");
	AST_ROM: assert property (cmd_done && cmd_op == lan_pkg::OP_READ_ROM && cmd_status == lan_pkg::STAT_OK |-> cmd_rdata == ROM_STATION)
		else $error("wrong station address read");
	AST_DL_READ: assert property (cmd_valid && cmd_op == lan_pkg::OP_DOWNLOAD && mem_req |-> !mem_we)
		else $error("download wrote system memory");
	AST_HALT_WRITE: assert property (cmd_valid && cmd_op == lan_pkg::OP_HALT && mem_req |-> mem_we)
		else $error("dump read system memory");
	AST_START_BOUND: assert property ($rose(cmd_valid) && cmd_op == lan_pkg::OP_START |-> ##[1:4] cmd_done)
		else $error("start not answered");
	cover property (cmd_done && cmd_status == lan_pkg::STAT_DUP_ADDR);
	cover property ($rose(resp_irq));
	cover property (cmd_done && cmd_op == lan_pkg::OP_DOWNLOAD && cmd_status == lan_pkg::STAT_OK);
endmodule // lan_controller_startup_selftest_props

// ### test/lan_controller_startup_selftest_tb.sv
// Bench joining the host end and the card end
`timescale 1ns/1ps
module lan_controller_startup_selftest_tb;
	localparam int CODE_CYC = 8;
	localparam int PASS_CYC = 20;
	localparam int LIM = 3000;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	lan_pkg::op_e req_op;
	logic [15:0] req_addr, req_len, load_addr;
	logic [47:0] req_data, resp_data, xid_dest;
	lan_pkg::stat_e resp_status;
	logic req_ready, resp_done, resp_irq_out, selftest_irq_out, progress_lamp, test_start;
	logic xid_send, command_queue_valid, rsp_ready, fw_running, test_done, test_pass, xid_echo;
	logic load_we = 1'b0, rsp_push = 1'b0, echo_on = 1'b0;
	logic [31:0] load_data, rsp_word, command_queue_word;
	logic [6:0] code_lamps, aui_lamps, test_code;
	logic [6:0] aui_act = 7'h00, ctl_act = 7'h2a, fail_code, last_code;
	int held, bad_count, checks_done, cq_seen, k, n;
	always #12.5 core_clk = ~core_clk;
	lan_link_if link ();
	lan_host_end lan_host_end_i (.link(link), .core_clk(core_clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_len(req_len), .req_data(req_data),
		.req_ready(req_ready), .resp_done(resp_done), .resp_status(resp_status), .resp_data(resp_data),
		.resp_irq_out(resp_irq_out), .selftest_irq_out(selftest_irq_out), .load_we(load_we),
		.load_addr(load_addr), .load_data(load_data));
	// Short timers keep the run brief
	lan_dev_end #(.FLASH_CYC(40), .CODE_CYC(CODE_CYC), .PASS_CYC(PASS_CYC),
		.FAIL_CYC(60), .BLINK_CYC(4), .DAC_CYC(10)) lan_dev_end_i (.link(link), .core_clk(core_clk),
		.rst_n(rst_n), .progress_lamp(progress_lamp), .code_lamps(code_lamps), .aui_lamps(aui_lamps),
		.aui_act(aui_act), .ctl_act(ctl_act), .test_start(test_start), .test_code(test_code),
		.test_done(test_done), .test_pass(test_pass), .xid_send(xid_send), .xid_dest(xid_dest),
		.xid_echo(xid_echo), .command_queue_valid(command_queue_valid), .command_queue_word(command_queue_word),
		.rsp_push(rsp_push), .rsp_word(rsp_word), .rsp_ready(rsp_ready), .fw_running(fw_running));
	lan_controller_startup_selftest_props lan_controller_startup_selftest_props_i (.core_clk(core_clk),
		.rst_n(rst_n), .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .cmd_done(link.cmd_done),
		.cmd_status(link.cmd_status), .cmd_rdata(link.cmd_rdata), .mem_req(link.mem_req), .mem_we(link.mem_we),
		.mem_addr(link.mem_addr), .mem_ack(link.mem_ack), .resp_irq(link.resp_irq),
		.selftest_irq(link.selftest_irq));
	task automatic chk(input logic [47:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic guard(input int c);
		if (c >= LIM)
		begin
			bad_count++;
			$display("[ERR] %0t wait timed out", $time);
			summarize();
		end
	endtask
	// Test and echo responders, code monitor
	always @(posedge core_clk)
	begin
		test_done <= test_start;
		test_pass <= test_code != fail_code;
		xid_echo <= xid_send && echo_on;
		cq_seen <= cq_seen + int'(command_queue_valid);
		held <= held + 1;
		if (rst_n && test_start === 1'b1)
		begin
			chk(48'(test_code), 48'(last_code + 7'h01));
			if (last_code != 7'h00)
				chk(48'(held >= CODE_CYC - 1), 48'h1);
			last_code <= test_code;
			held <= 0;
		end
	end
	task automatic do_reset(input logic [6:0] fc);
		rst_n <= 1'b0;
		fail_code <= fc;
		last_code <= 7'h00;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
	endtask
	task automatic hop(input lan_pkg::op_e op, input logic [15:0] a, l, input logic [47:0] d,
		input lan_pkg::stat_e es);
		req_op <= op;
		req_addr <= a;
		req_len <= l;
		req_data <= d;
		req_valid <= 1'b1;
		// Held until ready is sampled
		for (k = 0; k < LIM; k++)
		begin
			@(posedge core_clk);
			if (req_ready === 1'b1)
				break;
		end
		guard(k);
		req_valid <= 1'b0;
		for (k = 0; k < LIM && resp_done !== 1'b1; k++)
			@(posedge core_clk);
		guard(k);
		chk(48'(resp_status), 48'(es));
	endtask
	task automatic ld(input logic [15:0] a, input logic [31:0] d);
		load_we <= 1'b1;
		load_addr <= a;
		load_data <= d;
		@(posedge core_clk);
	endtask
	task automatic t_fail();
		do_reset(7'h05);
		for (k = 0; k < LIM && !(last_code == 7'h05 && held > CODE_CYC + 4); k++)
			@(posedge core_clk);
		guard(k);
		n = 0;
		repeat (40)
		begin
			@(posedge core_clk);
			chk(48'(code_lamps), 48'h5);
			n += int'(progress_lamp);
		end
		chk(48'(n > 0 && n < 40), 48'h1);
		hop(lan_pkg::OP_READ_ROM, 16'h0, 16'h0, 48'h0, lan_pkg::STAT_OK);
		chk(resp_data, lan_pkg::ROM_STATION);
		for (k = 0; k < LIM && !(progress_lamp === 1'b0 && code_lamps === ctl_act); k++)
			@(posedge core_clk);
		guard(k);
		aui_act <= 7'h55;
		repeat (2) @(posedge core_clk);
		chk(48'(aui_lamps), 48'h55);
	endtask
	task automatic t_pass();
		do_reset(7'h00);
		hop(lan_pkg::OP_READ_ROM, 16'h0, 16'h0, 48'h0, lan_pkg::STAT_BUSY);
		n = 0;
		repeat (25)
		begin
			@(posedge core_clk);
			chk(48'(code_lamps), 48'({7{progress_lamp}}));
			n += int'(progress_lamp);
		end
		chk(48'(n > 0 && n < 25), 48'h1);
		for (k = 0; k < LIM && !(progress_lamp === 1'b1 && code_lamps === 7'h00); k++)
			@(posedge core_clk);
		guard(k);
		chk(48'(last_code), 48'(lan_pkg::CODE_LAST));
		for (n = 0; n < LIM && progress_lamp === 1'b1 && code_lamps === 7'h00; n++)
			@(posedge core_clk);
		chk(48'(n >= PASS_CYC - 2 && n <= PASS_CYC + 2), 48'h1);
		repeat (2) @(posedge core_clk);
		chk(48'({progress_lamp, code_lamps}), 48'({1'b0, ctl_act}));
		chk(48'(selftest_irq_out), 48'h1);
	endtask
	task automatic t_fw();
		hop(lan_pkg::OP_START, 16'h0, 16'h0, 48'h0, lan_pkg::STAT_REFUSED);
		for (n = 0; n < 6; n++)
			ld(16'h0100 + 16'(n), 32'ha5a5_0000 + 32'(n));
		load_we <= 1'b0;
		hop(lan_pkg::OP_DOWNLOAD, 16'h0100, 16'h0004, 48'h0, lan_pkg::STAT_OK);
		hop(lan_pkg::OP_DOWNLOAD, 16'h0104, 16'h0002, 48'h0004_0000_0000, lan_pkg::STAT_OK);
		hop(lan_pkg::OP_START, 16'h0, 16'h0, 48'h0, lan_pkg::STAT_OK);
		chk(48'(fw_running), 48'h1);
		echo_on <= 1'b1;
		hop(lan_pkg::OP_SET_ADDR, 16'h0, 16'h0, 48'h0200_0000_0001, lan_pkg::STAT_DUP_ADDR);
		chk(xid_dest, 48'h0200_0000_0001);
		echo_on <= 1'b0;
		hop(lan_pkg::OP_SET_ADDR, 16'h0, 16'h0, 48'h0200_0000_0002, lan_pkg::STAT_OK);
	endtask
	task automatic t_queue();
		hop(lan_pkg::OP_POLL, 16'h0, 16'h0, 48'h0, lan_pkg::STAT_REFUSED);
		hop(lan_pkg::OP_CMDQ_CFG, 16'h0200, 16'h0004, 48'h1, lan_pkg::STAT_OK);
		hop(lan_pkg::OP_RSPQ_CFG, 16'h0300, 16'h0004, 48'h1, lan_pkg::STAT_OK);
		ld(16'h0201, 32'h0000_0002);
		ld(16'h0202, 32'h0000_0011);
		ld(16'h0203, 32'h0000_0022);
		load_we <= 1'b0;
		n = cq_seen;
		hop(lan_pkg::OP_POLL, 16'h0, 16'h0, 48'h0, lan_pkg::STAT_OK);
		chk(48'(cq_seen - n), 48'h2);
		chk(48'(command_queue_word), 48'h22);
		for (k = 0; k < LIM && rsp_ready !== 1'b1; k++)
			@(posedge core_clk);
		guard(k);
		rsp_push <= 1'b1;
		rsp_word <= 32'h0bad_cafe;
		@(posedge core_clk);
		rsp_push <= 1'b0;
		for (k = 0; k < LIM && resp_irq_out !== 1'b1; k++)
			@(posedge core_clk);
		guard(k);
		hop(lan_pkg::OP_CLR_IRQ, 16'h0, 16'h0, 48'h0, lan_pkg::STAT_OK);
		repeat (3) @(posedge core_clk);
		chk(48'({resp_irq_out, selftest_irq_out}), 48'h0);
		hop(lan_pkg::OP_HALT, 16'h0800, 16'h0, 48'h0, lan_pkg::STAT_OK);
	endtask
	initial
	begin
		t_fail();
		t_pass();
		t_fw();
		t_queue();
		summarize();
	end
endmodule // lan_controller_startup_selftest_tb
